// ==== hw/rtc_pkg.sv ====
// shared constants, carriers and register map for the serial rtc block
package rtc_pkg;
  // register addresses
  localparam logic [3:0] A_SEC_U = 4'h0;
  localparam logic [3:0] A_SEC_T = 4'h1;
  localparam logic [3:0] A_MIN_U = 4'h2;
  localparam logic [3:0] A_MIN_T = 4'h3;
  localparam logic [3:0] A_HR_U  = 4'h4;
  localparam logic [3:0] A_HR_T  = 4'h5;
  localparam logic [3:0] A_WDAY  = 4'h6;
  localparam logic [3:0] A_SPARE = 4'h7;
  localparam logic [3:0] A_DAY_U = 4'h8;
  localparam logic [3:0] A_DAY_T = 4'h9;
  localparam logic [3:0] A_MON_U = 4'hA;
  localparam logic [3:0] A_MON_T = 4'hB;
  localparam logic [3:0] A_YR_U  = 4'hC;
  localparam logic [3:0] A_YR_T  = 4'hD;
  localparam logic [3:0] A_CR1   = 4'hE;
  localparam logic [3:0] A_CR2   = 4'hF;
  // field positions
  localparam int CR1_ADJ  = 0;
  localparam int CR1_CEN  = 1;
  localparam int CR2_TEST = 0;
  localparam int CR2_BANK = 1;
  localparam int CR2_H12  = 3;
  localparam int CLK_DIS  = 0;
  // bcd limits
  localparam logic [3:0] BCD_MAX    = 4'h9;
  localparam logic [2:0] SEC_T_MAX  = 3'h5;
  localparam logic [2:0] SEC_T_HALF = 3'h3;
  localparam logic [5:0] HR_MAX     = 6'h23;
  localparam logic [2:0] WDAY_MAX   = 3'h6;
  localparam logic [4:0] MON_MAX    = 5'h12;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUSY_MAX_NS   = 122100;
  localparam int BUSY_CYC_DEF  = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int HALT_NS       = 1000000;
  localparam int HALT_CYC_DEF  = HALT_NS / CLK_PERIOD_NS;
  localparam logic [14:0] DIV_TOP = 15'h7FFF;
  // serial unit: 4 address bits, 4 mode bits, 4 data bits, lsb first
  localparam logic [3:0] LINK_ADDR_END = 4'h3;
  localparam logic [3:0] LINK_DATA_POS = 4'h8;
  localparam logic [3:0] LINK_MODE_POS = 4'h4;
  localparam logic [3:0] LINK_LAST     = 4'hB;
  localparam logic [3:0] MODE_WRITE    = 4'h8;
  localparam logic [3:0] MODE_READ     = 4'hC;

  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] data;
  } rtcWrCmd_t;

  typedef struct packed {
    logic [3:0] yrT;
    logic [3:0] yrU;
    logic       monT;
    logic [3:0] monU;
    logic [1:0] dayT;
    logic [3:0] dayU;
    logic [2:0] wday;
    logic [1:0] hrT;
    logic [3:0] hrU;
    logic [2:0] minT;
    logic [3:0] minU;
    logic [2:0] secT;
    logic [3:0] secU;
  } rtcCal_t;

  // 00-01-01 00:00:00, weekday 0
  localparam rtcCal_t CAL_RST = '{yrT: 4'h0, yrU: 4'h0, monT: 1'b0,
    monU: 4'h1, dayT: 2'h0, dayU: 4'h1, wday: 3'h0, hrT: 2'h0,
    hrU: 4'h0, minT: 3'h0, minU: 4'h0, secT: 3'h0, secU: 4'h0};
endpackage

// ==== hw/rtc_sync3.sv ====
// three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
module rtc_sync3 #(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1Q;
  logic [W-1:0] s2Q;
  logic [W-1:0] s3Q;
  logic [W-1:0] lvlQ;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          s1Q[i]  <= 1'b0;
          s2Q[i]  <= 1'b0;
          s3Q[i]  <= 1'b0;
          lvlQ[i] <= 1'b0;
        end
        else
        begin
          s1Q[i] <= din[i];
          s2Q[i] <= s1Q[i];
          s3Q[i] <= s2Q[i];
          // change counts only once stages two and three agree
          if (s2Q[i] == s3Q[i])
            lvlQ[i] <= s3Q[i];
        end
      end
    end
  endgenerate

  assign dout = lvlQ;
endmodule

// ==== hw/rtc_serial_link.sv ====
// serial link shifter on the host's shift clock, chip-enable framed
`timescale 1ns/1ps
module rtc_serial_link
  import rtc_pkg::*;
(
  input  wire logic      serClk,
  input  wire logic      nrst,
  input  wire logic      ce,
  input  wire logic      sioIn,
  input  wire logic [3:0] rdNib,
  output logic           sioOut,
  output logic           sioOe,
  output logic           rdTog,
  output logic           wrTog,
  output logic     [3:0] rdAddr,
  output rtcWrCmd_t      wrCmd
);
  logic       frameRst_n;
  logic [3:0] bitQ;
  logic [3:0] addrQ;
  logic [3:0] modeQ;
  logic [3:0] dataQ;

  // frame state dies with chip enable; the clock may stop outside frames
  assign frameRst_n = nrst & ce;

  wire lastBit  = bitQ == LINK_LAST;
  wire addrDone = ce && (bitQ == LINK_ADDR_END);
  wire wrDone   = ce && lastBit && (modeQ == MODE_WRITE);
  wire rdPhase  = (modeQ == MODE_READ) && (bitQ >= LINK_DATA_POS);

  always_ff @(posedge serClk or negedge frameRst_n)
  begin
    if (!frameRst_n)
    begin
      bitQ  <= 4'h0;
      addrQ <= 4'h0;
      modeQ <= 4'h0;
      dataQ <= 4'h0;
    end
    else
    begin
      bitQ <= lastBit ? 4'h0 : bitQ + 4'h1;
      if (bitQ < LINK_MODE_POS)
        addrQ[bitQ[1:0]] <= sioIn;
      else if (bitQ < LINK_DATA_POS)
        modeQ[bitQ[1:0]] <= sioIn;
      else
        dataQ[bitQ[1:0]] <= sioIn;
    end
  end

  // read is requested early so the core answers before the data bits
  always_ff @(posedge serClk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdTog  <= 1'b0;
      wrTog  <= 1'b0;
      rdAddr <= 4'h0;
      wrCmd  <= '0;
    end
    else
    begin
      if (addrDone)
      begin
        rdAddr <= {sioIn, addrQ[2:0]};
        rdTog  <= ~rdTog;
      end
      if (wrDone)
      begin
        wrCmd <= '{addr: addrQ, data: {sioIn, dataQ[2:0]}};
        wrTog <= ~wrTog;
      end
    end
  end

  always_ff @(negedge serClk or negedge frameRst_n)
  begin
    if (!frameRst_n)
    begin
      sioOe  <= 1'b0;
      sioOut <= 1'b0;
    end
    else
    begin
      sioOe  <= rdPhase;
      sioOut <= rdNib[bitQ[1:0]];
    end
  end
endmodule

// ==== hw/rtc_counter_core.sv ====
// serial rtc: calendar counters, control registers, link hand-off
`timescale 1ns/1ps
// Behaviour
// - bank 0: BCD counters at 0h..Dh, units digit first
// - unimplemented bits ignore writes and read as zero
// - spare nibble at 7h, read/write in both banks, no side effect
// - bank 1: address Ah is output-clock control, active-low bit D0
// - spare and both control registers ignore the bank bit
// - control 1 D0: write requests seconds rounding, read gives busy
// - control 1 D1: write sets carry enable, read gives halt flag
// - chip enable low forces carry enable and test bit to one
// - output-clock disable cleared at power-on and when halt sets
// - busy reads one while a carry or rounding updates counters
// - carry enable zero holds off the one-second carry
// - halt flag reads one once oscillator stop is sensed while chip enable is low
// - rounding clears sub-seconds and seconds; 30-59 adds a minute
// - busy after rounding lasts no longer than 122.1 us
// - carry held while disabled applies once when re-enabled
// - control 1 write with running oscillator clears halt flag
module rtc_counter_core
  import rtc_pkg::*;
#(
  parameter int BUSY_CYC = BUSY_CYC_DEF,
  parameter int HALT_CYC = HALT_CYC_DEF
)
(
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic serClk,
  input  wire logic ce,
  input  wire logic sioIn,
  input  wire logic oscIn,
  output logic      sioOut,
  output logic      sioOe,
  output logic      squareWaveOut,
  output logic      squareWaveOe
);
  localparam logic [13:0] BUSY_LOAD = 14'(BUSY_CYC);
  localparam logic [16:0] HALT_LIM  = 17'(HALT_CYC);

  logic      [3:0] syncLvl;
  logic            ceLvl;
  logic            oscLvl;
  logic            rdLvl;
  logic            wrLvl;
  logic            rdTog;
  logic            wrTog;
  logic      [3:0] rdAddr;
  rtcWrCmd_t       wrCmd;
  logic [15:0][3:0] calView;
  logic      [3:0] bankView;
  logic      [3:0] rdNibD;
  rtcCal_t         calD;
  rtcCal_t         calQ;
  logic     [14:0] divD;
  logic     [14:0] divQ;
  logic     [16:0] stallD;
  logic     [16:0] stallQ;
  logic     [13:0] busyCntD;
  logic     [13:0] busyCntQ;
  logic            oscPrevQ;
  logic            rdPrevQ;
  logic            wrPrevQ;
  logic            bankQ;
  logic            testQ;
  logic            h12Q;
  logic      [3:0] spareQ;
  logic            carryEnD;
  logic            carryEnQ;
  logic            haltD;
  logic            haltQ;
  logic            clkDisD;
  logic            clkDisQ;
  logic            adjPendQ;
  logic            carryPendQ;
  logic      [3:0] rdDataQ;
  logic            swOeQ;
  logic            bumpMin;
  logic            bumpHr;
  logic            bumpDay;
  logic            bumpMon;
  logic            bumpYr;

  rtc_serial_link u_link (
    .serClk (serClk),
    .nrst   (nrst),
    .ce     (ce),
    .sioIn  (sioIn),
    .rdNib  (rdDataQ),
    .sioOut (sioOut),
    .sioOe  (sioOe),
    .rdTog  (rdTog),
    .wrTog  (wrTog),
    .rdAddr (rdAddr),
    .wrCmd  (wrCmd)
  );

  // link toggles cross as levels; command and address words stay put
  rtc_sync3 #(.W(4)) u_sync (
    .clk  (core_clk),
    .nrst (nrst),
    .din  ({ce, oscIn, rdTog, wrTog}),
    .dout (syncLvl)
  );

  assign ceLvl  = syncLvl[3];
  assign oscLvl = syncLvl[2];
  assign rdLvl  = syncLvl[1];
  assign wrLvl  = syncLvl[0];

  // events
  wire oscRise = oscLvl & ~oscPrevQ;
  wire rdEv    = rdLvl ^ rdPrevQ;
  wire wrEv    = wrLvl ^ wrPrevQ;
  wire tick    = oscRise && (divQ == DIV_TOP);
  wire busyQ   = busyCntQ != 14'h0;
  wire oscStop = stallQ == HALT_LIM;

  // write decode
  wire wrIsCal  = (wrCmd.addr <= A_YR_T) && (wrCmd.addr != A_SPARE);
  wire ctrWr    = wrEv && !bankQ && wrIsCal;
  wire clkCtlWr = wrEv && bankQ && (wrCmd.addr == A_MON_U);
  wire spareWr  = wrEv && (wrCmd.addr == A_SPARE);
  wire cr1Wr    = wrEv && (wrCmd.addr == A_CR1);
  wire cr2Wr    = wrEv && (wrCmd.addr == A_CR2);

  // a host counter write this cycle defers carry and rounding by one
  wire applyCarry = carryPendQ && carryEnQ && !ctrWr;
  wire applyAdj   = adjPendQ && carryEnQ && !ctrWr;
  wire haltSet    = oscStop && !ceLvl;

  function automatic logic [5:0] lastDay(input rtcCal_t c);
    logic leap;
    leap = c.yrT[0] ? (c.yrU == 4'h2 || c.yrU == 4'h6)
                    : (c.yrU == 4'h0 || c.yrU == 4'h4 || c.yrU == 4'h8);
    case ({c.monT, c.monU})
      5'h02:   lastDay = leap ? 6'h29 : 6'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   lastDay = 6'h30;
      default: lastDay = 6'h31;
    endcase
  endfunction

  // calendar next state
  always_comb
  begin
    calD    = calQ;
    bumpMin = 1'b0;
    bumpHr  = 1'b0;
    bumpDay = 1'b0;
    bumpMon = 1'b0;
    bumpYr  = 1'b0;
    if (ctrWr)
    begin
      // part-selects drop the unimplemented high bits
      case (wrCmd.addr)
        A_SEC_U: calD.secU = wrCmd.data;
        A_SEC_T: calD.secT = wrCmd.data[2:0];
        A_MIN_U: calD.minU = wrCmd.data;
        A_MIN_T: calD.minT = wrCmd.data[2:0];
        A_HR_U:  calD.hrU  = wrCmd.data;
        A_HR_T:  calD.hrT  = wrCmd.data[1:0];
        A_WDAY:  calD.wday = wrCmd.data[2:0];
        A_DAY_U: calD.dayU = wrCmd.data;
        A_DAY_T: calD.dayT = wrCmd.data[1:0];
        A_MON_U: calD.monU = wrCmd.data;
        A_MON_T: calD.monT = wrCmd.data[0];
        A_YR_U:  calD.yrU  = wrCmd.data;
        A_YR_T:  calD.yrT  = wrCmd.data;
        default: calD = calQ;
      endcase
    end
    else if (applyAdj)
    begin
      calD.secU = 4'h0;
      calD.secT = 3'h0;
      bumpMin   = calQ.secT >= SEC_T_HALF;
    end
    else if (applyCarry)
    begin
      if (calQ.secU == BCD_MAX)
      begin
        calD.secU = 4'h0;
        bumpMin   = calQ.secT == SEC_T_MAX;
        calD.secT = bumpMin ? 3'h0 : calQ.secT + 3'h1;
      end
      else
        calD.secU = calQ.secU + 4'h1;
    end
    if (bumpMin)
    begin
      if (calQ.minU == BCD_MAX)
      begin
        calD.minU = 4'h0;
        bumpHr    = calQ.minT == SEC_T_MAX;
        calD.minT = bumpHr ? 3'h0 : calQ.minT + 3'h1;
      end
      else
        calD.minU = calQ.minU + 4'h1;
    end
    if (bumpHr)
    begin
      bumpDay = {calQ.hrT, calQ.hrU} == HR_MAX;
      if (bumpDay)
      begin
        calD.hrT = 2'h0;
        calD.hrU = 4'h0;
      end
      else if (calQ.hrU == BCD_MAX)
      begin
        calD.hrU = 4'h0;
        calD.hrT = calQ.hrT + 2'h1;
      end
      else
        calD.hrU = calQ.hrU + 4'h1;
    end
    if (bumpDay)
    begin
      calD.wday = (calQ.wday == WDAY_MAX) ? 3'h0 : calQ.wday + 3'h1;
      bumpMon   = {calQ.dayT, calQ.dayU} == lastDay(calQ);
      if (bumpMon)
      begin
        calD.dayT = 2'h0;
        calD.dayU = 4'h1;
      end
      else if (calQ.dayU == BCD_MAX)
      begin
        calD.dayU = 4'h0;
        calD.dayT = calQ.dayT + 2'h1;
      end
      else
        calD.dayU = calQ.dayU + 4'h1;
    end
    if (bumpMon)
    begin
      bumpYr = {calQ.monT, calQ.monU} == MON_MAX;
      if (bumpYr)
      begin
        calD.monT = 1'b0;
        calD.monU = 4'h1;
      end
      else if (calQ.monU == BCD_MAX)
      begin
        calD.monU = 4'h0;
        calD.monT = 1'b1;
      end
      else
        calD.monU = calQ.monU + 4'h1;
    end
    if (bumpYr)
    begin
      calD.yrU = (calQ.yrU == BCD_MAX) ? 4'h0 : calQ.yrU + 4'h1;
      if (calQ.yrU == BCD_MAX)
        calD.yrT = (calQ.yrT == BCD_MAX) ? 4'h0 : calQ.yrT + 4'h1;
    end
  end

  // divider, stall watch, busy timer
  assign divD = applyAdj ? 15'h0 : (oscRise ? divQ + 15'h1 : divQ);
  assign stallD = oscRise ? 17'h0 : (oscStop ? stallQ : stallQ + 17'h1);
  assign busyCntD = (applyAdj || applyCarry) ? BUSY_LOAD
                  : (busyQ ? busyCntQ - 14'h1 : 14'h0);

  // control bits; a forced value (ce low, halt set) in the same cycle beats a host write
  assign carryEnD = !ceLvl ? 1'b1
                  : (cr1Wr ? wrCmd.data[CR1_CEN] : carryEnQ);
  assign haltD = haltSet | (haltQ & ~(cr1Wr & ~oscStop));
  assign clkDisD = (haltSet && !haltQ) ? 1'b0
                 : (clkCtlWr ? wrCmd.data[CLK_DIS] : clkDisQ);

  // read view, nibble per address
  assign calView[A_SEC_U] = calQ.secU;
  assign calView[A_SEC_T] = {1'b0, calQ.secT};
  assign calView[A_MIN_U] = calQ.minU;
  assign calView[A_MIN_T] = {1'b0, calQ.minT};
  assign calView[A_HR_U]  = calQ.hrU;
  assign calView[A_HR_T]  = {2'h0, calQ.hrT};
  assign calView[A_WDAY]  = {1'b0, calQ.wday};
  assign calView[A_SPARE] = spareQ;
  assign calView[A_DAY_U] = calQ.dayU;
  assign calView[A_DAY_T] = {2'h0, calQ.dayT};
  assign calView[A_MON_U] = calQ.monU;
  assign calView[A_MON_T] = {3'h0, calQ.monT};
  assign calView[A_YR_U]  = calQ.yrU;
  assign calView[A_YR_T]  = calQ.yrT;
  assign calView[A_CR1]   = {2'h0, haltQ, busyQ};
  assign calView[A_CR2]   = {h12Q, 1'b0, bankQ, testQ};

  wire rdIsCal = (rdAddr <= A_YR_T) && (rdAddr != A_SPARE);
  assign bankView = (rdAddr == A_MON_U) ? {3'h0, clkDisQ} : 4'h0;
  assign rdNibD = (bankQ && rdIsCal) ? bankView : calView[rdAddr];

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      calQ     <= CAL_RST;
      divQ     <= 15'h0;
      stallQ   <= 17'h0;
      busyCntQ <= 14'h0;
    end
    else
    begin
      calQ     <= calD;
      divQ     <= divD;
      stallQ   <= stallD;
      busyCntQ <= busyCntD;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oscPrevQ <= 1'b0;
      rdPrevQ  <= 1'b0;
      wrPrevQ  <= 1'b0;
      rdDataQ  <= 4'h0;
    end
    else
    begin
      oscPrevQ <= oscLvl;
      rdPrevQ  <= rdLvl;
      wrPrevQ  <= wrLvl;
      if (rdEv)
        rdDataQ <= rdNibD;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      carryEnQ   <= 1'b1;
      haltQ      <= 1'b1;
      clkDisQ    <= 1'b0;
      adjPendQ   <= 1'b0;
      carryPendQ <= 1'b0;
    end
    else
    begin
      carryEnQ   <= carryEnD;
      haltQ      <= haltD;
      clkDisQ    <= clkDisD;
      adjPendQ   <= (cr1Wr && wrCmd.data[CR1_ADJ]) || (adjPendQ && !applyAdj);
      carryPendQ <= tick || (carryPendQ && !applyCarry);
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bankQ   <= 1'b0;
      testQ   <= 1'b1;
      h12Q    <= 1'b0;
      spareQ  <= 4'h0;
    end
    else
    begin
      if (cr2Wr)
      begin
        bankQ <= wrCmd.data[CR2_BANK];
        h12Q  <= wrCmd.data[CR2_H12];
      end
      testQ <= !ceLvl ? 1'b1 : (cr2Wr ? wrCmd.data[CR2_TEST] : testQ);
      if (spareWr)
        spareQ <= wrCmd.data;
    end
  end

  // open drain: pull low on the low half of each oscillator cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      swOeQ         <= 1'b0;
      squareWaveOut <= 1'b0;
    end
    else
    begin
      swOeQ         <= !clkDisQ && !oscLvl;
      squareWaveOut <= 1'b0;
    end
  end
  assign squareWaveOe = swOeQ;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence sAdjMinute;
    applyAdj && (calQ.secT >= SEC_T_HALF) && (calQ.minU < BCD_MAX);
  endsequence

  sequence sHeldCarry;
    tick && !carryEnQ ##1 carryPendQ;
  endsequence

  a_adj_zeroes: assert property (applyAdj |=> calQ.secU == 4'h0
    && calQ.secT == 3'h0 && divQ == 15'h0)
    else $error("rounding left seconds nonzero");
  a_adj_minute: assert property (sAdjMinute |=>
    calQ.minU == $past(calQ.minU) + 4'h1)
    else $error("rounding from 30-59 did not add a minute");
  a_carry_held: assert property (sHeldCarry |->
    $stable(calQ.secU) || $past(ctrWr))
    else $error("carry not held while disabled");
  a_carry_busy: assert property (applyCarry |=>
    busyQ && !carryPendQ [*2])
    else $error("carry without busy");
  a_busy_bound: assert property ($rose(busyQ) |->
    busyCntQ == BUSY_LOAD)
    else $error("busy window exceeds its limit");
  a_ce_force: assert property (!ceLvl |=> carryEnQ && testQ)
    else $error("chip enable low did not force bits");
  a_halt_dis: assert property (haltSet && !haltQ |=>
    haltQ && !clkDisQ)
    else $error("halt did not enable clock output");
  a_halt_clear: assert property (cr1Wr && !oscStop && !haltSet
    |=> !haltQ)
    else $error("control write did not clear halt");
  a_spare_rw: assert property (spareWr |=>
    spareQ == $past(wrCmd.data) && $stable(calQ))
    else $error("spare nibble write misbehaved");
  a_bank_view: assert property (rdEv && bankQ
    && rdAddr == A_MON_U |=> rdDataQ == {3'h0, $past(clkDisQ)})
    else $error("bank one read of Ah wrong");
  a_cr1_read: assert property (rdEv && rdAddr == A_CR1 |=>
    rdDataQ == {2'h0, $past(haltQ), $past(busyQ)})
    else $error("control 1 read wrong");
endmodule

// ==== test/rtc_host_model.sv ====
// host controller model driving the chip-enable framed serial link
`timescale 1ns/1ps
module rtc_host_model
  import rtc_pkg::*;
(
  output logic      serClk,
  output logic      ce,
  output logic      sioIn,
  input  wire logic sioOut,
  input  wire logic sioOe
);
  logic hostOe;
  logic hostBit;
  logic idleBit;

  // released wire flips every shift so a stale level never reads back
  assign sioIn = sioOe ? sioOut : (hostOe ? hostBit : idleBit);

  initial
  begin
    serClk = 1'b0;
    ce = 1'b0;
    hostOe = 1'b1;
    hostBit = 1'b0;
    idleBit = 1'b0;
  end

  always @(posedge serClk) idleBit <= ~idleBit;

  task automatic open_frame();
    #40 ce = 1'b1;
    #40;
  endtask

  // ce low also restores carry enable and normal mode
  task automatic close_frame();
    #40 ce = 1'b0;
    #40;
  endtask

  // serial clock only runs inside a frame
  task automatic send_unit(input logic [3:0] addr, input logic [3:0] mode,
                           input logic [3:0] data, output logic [3:0] rd);
    logic [11:0] bits;
    bits = {data, mode, addr};
    rd = 4'h0;
    for (int i = 0; i < 12; i++)
    begin
      hostOe = (mode != MODE_READ) || (i < 8);
      hostBit = bits[i];
      #15 serClk = 1'b1;
      if (i >= 8)
        rd[i-8] = sioIn;
      #15 serClk = 1'b0;
    end
    hostOe = 1'b1;
  endtask
endmodule

// ==== test/rtc_counter_core_test.sv ====
// self-checking bench for the serial rtc counter block
`timescale 1ns/1ps
module rtc_counter_core_test
  import rtc_pkg::*;
;
  localparam int BUSY = 200;
  logic       core_clk;
  logic       nrst;
  logic       serClk;
  logic       ce;
  logic       sioIn;
  logic       sioOut;
  logic       sioOe;
  logic       oscIn;
  logic       oscRun;
  logic       squareWaveOut;
  logic       squareWaveOe;
  int         oscCnt;
  int         errors;
  int         samples_checked;
  logic [3:0] rd;
  logic [3:0] wr;
  logic [3:0] minU;
  logic [7:0] secs [4];

  rtc_counter_core #(
    .BUSY_CYC (BUSY),
    .HALT_CYC (50)
  ) rtc_counter_core_inst (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .serClk        (serClk),
    .ce            (ce),
    .sioIn         (sioIn),
    .oscIn         (oscIn),
    .sioOut        (sioOut),
    .sioOe         (sioOe),
    .squareWaveOut (squareWaveOut),
    .squareWaveOe  (squareWaveOe)
  );

  rtc_host_model rtc_host_model_inst (
    .serClk (serClk),
    .ce     (ce),
    .sioIn  (sioIn),
    .sioOut (sioOut),
    .sioOe  (sioOe)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // oscillator far faster than a crystal; the seconds tick never comes
  always @(negedge core_clk)
  begin
    if (oscRun)
      oscCnt <= (oscCnt == 4) ? 0 : oscCnt + 1;
    if (oscRun && oscCnt == 4)
      oscIn <= ~oscIn;
  end

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
    rtc_host_model_inst.send_unit(a, MODE_WRITE, d, rd);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp);
    logic [3:0] v;
    rtc_host_model_inst.send_unit(a, MODE_READ, 4'h0, v);
    check(v, exp);
  endtask

  // open drain: the data pin must never drive high, only the enable moves
  task automatic watch_square(input logic exp);
    logic seen;
    logic drv;
    seen = 1'b0;
    drv = 1'b0;
    repeat (40)
    begin
      @(negedge core_clk);
      seen |= squareWaveOe;
      drv |= squareWaveOut;
    end
    check({3'h0, seen}, {3'h0, exp});
    check({3'h0, drv}, 4'h0);
  endtask

  function automatic logic [3:0] mask_of(input logic [3:0] a);
    case (a)
      A_SEC_T, A_MIN_T, A_WDAY: mask_of = 4'h7;
      A_HR_T, A_DAY_T: mask_of = 4'h3;
      A_MON_T: mask_of = 4'h1;
      default: mask_of = 4'hF;
    endcase
  endfunction

  function automatic logic [3:0] exp_min(input logic [7:0] s,
                                         input logic [3:0] m);
    exp_min = (s[7:4] >= 4'h3) ? m + 4'h1 : m;
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #300000;
    errors++;
    give_verdict();
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    nrst = 1'b0;
    oscIn = 1'b0;
    oscCnt = 0;
    oscRun = 1'b1;
    secs = '{8'h29, 8'h30, 8'h59, 8'h00};
    void'($urandom(32'h82ff3e7d));
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'b1;
    repeat (12) @(negedge core_clk);
    rtc_host_model_inst.open_frame();
    rd_chk(A_MON_U, 4'h1);
    rd_chk(A_CR2, 4'h1);
    rd_chk(A_CR1, 4'h2);
    wr_reg(A_CR1, 4'h0);
    rd_chk(A_CR1, 4'h0);
    for (int i = 0; i < 14; i++)
    begin
      wr = (i == 0) ? 4'hF : 4'($urandom);
      wr_reg(4'(i), wr);
      rd_chk(4'(i), wr & mask_of(4'(i)));
    end
    wr_reg(A_CR2, 4'hF);
    rd_chk(A_CR2, 4'hB);
    wr_reg(A_CR2, 4'h3);
    rd_chk(A_CR2, 4'h3);
    wr_reg(A_SPARE, 4'hA);
    rd_chk(A_SPARE, 4'hA);
    rd_chk(A_MON_U, 4'h0);
    wr_reg(A_MON_U, 4'hF);
    rd_chk(A_MON_U, 4'h1);
    wr_reg(A_SEC_U, 4'h5);
    wr_reg(A_CR2, 4'h0);
    rd_chk(A_CR2, 4'h0);
    rd_chk(A_SEC_U, 4'hF);
    rtc_host_model_inst.close_frame();
    watch_square(1'b0);
    rtc_host_model_inst.open_frame();
    rd_chk(A_CR2, 4'h1);
    rtc_host_model_inst.close_frame();
    for (int k = 0; k < 4; k++)
    begin
      if (k == 3)
        secs[3] = {4'($urandom_range(5)), 4'($urandom_range(9))};
      minU = 4'($urandom_range(8));
      rtc_host_model_inst.open_frame();
      wr_reg(A_CR1, 4'h0);
      wr_reg(A_SEC_U, secs[k][3:0]);
      wr_reg(A_SEC_T, secs[k][7:4]);
      wr_reg(A_MIN_U, minU);
      wr_reg(A_MIN_T, 4'h0);
      wr_reg(A_CR1, 4'h1);
      rd_chk(A_SEC_T, secs[k][7:4]);
      rtc_host_model_inst.close_frame();
      rtc_host_model_inst.open_frame();
      rd_chk(A_CR1, 4'h1);
      rd_chk(A_SEC_U, 4'h0);
      rd_chk(A_SEC_T, 4'h0);
      rd_chk(A_MIN_U, exp_min(secs[k], minU));
      rtc_host_model_inst.close_frame();
      repeat (BUSY + 10) @(negedge core_clk);
      rtc_host_model_inst.open_frame();
      rd_chk(A_CR1, 4'h0);
      rtc_host_model_inst.close_frame();
    end
    rtc_host_model_inst.open_frame();
    wr_reg(A_CR2, 4'h3);
    wr_reg(A_MON_U, 4'h1);
    rtc_host_model_inst.close_frame();
    oscRun = 1'b0;
    repeat (100) @(negedge core_clk);
    oscRun = 1'b1;
    watch_square(1'b1);
    rtc_host_model_inst.open_frame();
    rd_chk(A_CR1, 4'h2);
    rd_chk(A_MON_U, 4'h0);
    wr_reg(A_CR1, 4'h2);
    rd_chk(A_CR1, 4'h0);
    rtc_host_model_inst.close_frame();
    give_verdict();
  end
endmodule
